//--- sim/pcg_gate_ctrl_tb.sv
// Testbench: register access, clock gating and stop handshake flag
`timescale 1ns/1ps
module pcg_gate_ctrl_tb;
  import pcg_pkg::*;
  logic                  i_ref_clk, i_resetn, stop_req, ack, o_stop_violation;
  pcg_bus_req_t          i_bus;
  logic [PCG_DW-1:0]     o_rdata, o_gate_ctrl_two;
  logic [PCG_NGATES-1:0] o_periph_clk;
  int                    edges [6];
  int                    base [6];
  int                    pos [6] = '{0, 1, 2, 3, 4, 6};
  int                    fail_count, cmp_count;

  pcg_gate_ctrl uut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_bus(i_bus),
    .i_serial_stop_ack(ack), .o_rdata(o_rdata), .o_periph_clk(o_periph_clk),
    .o_gate_ctrl_two(o_gate_ctrl_two), .o_stop_violation(o_stop_violation));
  pcg_periph_model peer (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_stop_req(stop_req),
    .i_periph_clk(o_periph_clk), .o_stop_ack(ack), .o_edges(edges));

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Bus and compare tasks
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(posedge i_ref_clk);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask
  task automatic idle();
    @(posedge i_ref_clk);
    i_bus <= '0;
  endtask
  task automatic rd(logic [15:0] a, logic [15:0] exp);
    @(posedge i_ref_clk);
    i_bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    idle();
    #1 chk("rdata", exp, o_rdata);
  endtask
  task automatic clocks(logic [5:0] stopped);
    repeat (3) @(posedge i_ref_clk);
    #1 base = edges;
    repeat (4) @(posedge i_ref_clk);
    #1;
    for (int i = 0; i < 6; i++) begin
      chk("gated clock edges", stopped[i] ? 16'h0000 : 16'h0004, 16'(edges[i] - base[i]));
    end
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    i_resetn = 1'b0;
    i_bus = '0;
    stop_req = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    rd(PCG_OFS_ONE, 16'h0000);
    rd(PCG_OFS_TWO, 16'h0000);
    clocks(6'h00);
    for (int i = 0; i < 6; i++) begin
      stop_req <= (i == 2);
      repeat (3) @(posedge i_ref_clk);
      rd(PCG_OFS_STAT, (i == 2) ? 16'h0002 : 16'h0000);
      wr(PCG_OFS_ONE, 16'h0020 | (16'h0001 << pos[i]));
      rd(PCG_OFS_ONE, 16'h0020 | (16'h0001 << pos[i]));
      clocks(6'h01 << i);
      wr(PCG_OFS_ONE, 16'h0020);
      idle();
      clocks(6'h00);
    end
    wr(PCG_OFS_ONE, 16'h0024);
    rd(PCG_OFS_STAT, 16'h0001);
    chk("stop violation", {15'h0000, 1'b1}, {15'h0000, o_stop_violation});
    wr(PCG_OFS_STAT, 16'h0001);
    rd(PCG_OFS_STAT, 16'h0000);
    wr(PCG_OFS_TWO, 16'ha5c3);
    rd(PCG_OFS_TWO, 16'ha5c3);
    chk("second register", 16'ha5c3, o_gate_ctrl_two);
    wr(PCG_OFS_ONE, 16'hffa0);
    rd(PCG_OFS_ONE, 16'h0020);
    wr(16'h1c05, 16'hffff);
    rd(16'h1c05, 16'h0000);
    rd(PCG_OFS_TWO, 16'ha5c3);
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge i_ref_clk);
    fail_count++;
    report_and_stop();
  end
endmodule // pcg_gate_ctrl_tb

//--- sim/pcg_periph_model.sv
// Far side: clock-stop handshake and edge counters of the gated clocks
`timescale 1ns/1ps
module pcg_periph_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_stop_req,
  input  wire logic [5:0] i_periph_clk,
  output logic            o_stop_ack,
  output int              o_edges [6]
);
  logic [1:0] dly;
  ////////////////////////////////////////////////////////////////////////////////
  // Acknowledge two cycles after a stop request, drop one cycle after it falls
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dly <= 2'b00;
    end else begin
      dly <= {dly[0], i_stop_req} & {2{i_stop_req}};
    end
  end
  assign o_stop_ack = dly[1];
  ////////////////////////////////////////////////////////////////////////////////
  // Rising edges seen by each peripheral
  for (genvar g = 0; g < 6; g++) begin : g_cnt
    initial o_edges[g] = 0;
    always @(posedge i_periph_clk[g]) begin
      o_edges[g]++;
    end
  end
endmodule // pcg_periph_model

//--- src/pcg_gate_ctrl.sv
// Peripheral clock gating register with latch-based glitch-free clock gates
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Bit 6 stops the two-wire clock when 1, runs it when 0
// - Bit 4 stops memory-card port 0 clock when 1
// - Bit 3 stops DMA controller 0 clock when 1
// - Bit 2 stops the UART clock when 1
// - Bit 1 stops the SPI controller clock when 1
// - Bit 0 stops audio serial port 3 clock when 1
// - Second gating register decodes at I/O address 1C03h
module pcg_gate_ctrl (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_resetn,
  input  wire pcg_pkg::pcg_bus_req_t         i_bus,
  input  wire logic                          i_serial_stop_ack,
  output logic [pcg_pkg::PCG_DW-1:0]         o_rdata,
  output logic [pcg_pkg::PCG_NGATES-1:0]     o_periph_clk,
  output logic [pcg_pkg::PCG_DW-1:0]         o_gate_ctrl_two,
  output logic                               o_stop_violation
);
  import pcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  pcg_state_t            st;
  pcg_state_t            next_st;
  logic                  wr_one;
  logic                  wr_two;
  logic                  wr_stat;
  logic                  viol_evt;
  logic [PCG_NGATES-1:0] gate_en;
  logic [PCG_NGATES-1:0] lat_en;

  // Address decode
  function automatic logic addr_hit(input logic [PCG_AW-1:0] a,
                                    input logic [PCG_AW-1:0] ofs);
    return a == ofs;
  endfunction

  // Read multiplexer, unmapped addresses read zero
  function automatic logic [PCG_DW-1:0] read_mux(input logic [PCG_AW-1:0] a,
                                                 input pcg_state_t s,
                                                 input logic ack);
    logic [PCG_DW-1:0] d;
    d = '0;
    if (addr_hit(a, PCG_OFS_ONE)) begin
      d[PCG_ONE_W-1:0] = s.gate_one;
    end else if (addr_hit(a, PCG_OFS_TWO)) begin
      d = s.gate_two;
    end else if (addr_hit(a, PCG_OFS_STAT)) begin
      d[PCG_STAT_VIOL] = s.stop_viol;
      d[PCG_STAT_ACK]  = ack;
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register file
  assign wr_one  = i_bus.wr && addr_hit(i_bus.addr, PCG_OFS_ONE);
  assign wr_two  = i_bus.wr && addr_hit(i_bus.addr, PCG_OFS_TWO);
  assign wr_stat = i_bus.wr && addr_hit(i_bus.addr, PCG_OFS_STAT);

  // UART gate set without acknowledge from the clock-stop handshake
  assign viol_evt = wr_one && i_bus.wdata[PCG_POS_SERIAL]
                  && !st.gate_one[PCG_POS_SERIAL] && !i_serial_stop_ack;

  always_comb begin
    next_st       = st;
    next_st.rdata = '0;
    if (wr_one) begin
      next_st.gate_one = i_bus.wdata[PCG_ONE_W-1:0];
    end
    if (wr_two) begin
      next_st.gate_two = i_bus.wdata;
    end
    if (wr_stat && i_bus.wdata[PCG_STAT_VIOL]) begin
      next_st.stop_viol = 1'b0;
    end
    if (viol_evt) begin
      next_st.stop_viol = 1'b1;
    end
    if (i_bus.rd) begin
      next_st.rdata = read_mux(i_bus.addr, st, i_serial_stop_ack);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st.gate_one  <= PCG_RST_ONE;
      st.gate_two  <= PCG_RST_TWO;
      st.rdata     <= '0;
      st.stop_viol <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata          = st.rdata;
  assign o_gate_ctrl_two  = st.gate_two;
  assign o_stop_violation = st.stop_viol;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock gates: a 1 in the gate bit stops the clock
  generate
    for (genvar k = 0; k < PCG_NGATES; k++) begin : g_gate
      assign gate_en[k] = !st.gate_one[pcg_gate_pos(k)];

      // Latch open only while the clock is low, so no partial high pulse
      always_latch begin
        if (!i_ref_clk) begin
          lat_en[k] = gate_en[k];
        end
      end

      assign o_periph_clk[k] = i_ref_clk & lat_en[k];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  logic [PCG_NGATES-1:0] lat_at_rise;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lat_at_rise <= '1;
    end else begin
      lat_at_rise <= lat_en;
    end
  end

  property gate_write_p(int pos, int idx);
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_bus.wr && i_bus.addr == PCG_OFS_ONE) ##1 !(i_bus.wr && i_bus.addr == PCG_OFS_ONE)
      |-> ##1 (lat_en[idx] == !$past(i_bus.wdata[pos], 2));
  endproperty

  twowire_gate_a: assert property (gate_write_p(PCG_POS_TWOWIRE, 5))
    else $error("Two-wire clock gate does not follow bit 6");

  card_gate_a: assert property (gate_write_p(PCG_POS_CARD0, 4))
    else $error("Card port 0 clock gate does not follow bit 4");

  dma_gate_a: assert property (gate_write_p(PCG_POS_DMA0, 3))
    else $error("DMA 0 clock gate does not follow bit 3");

  uart_gate_a: assert property (gate_write_p(PCG_POS_SERIAL, 2))
    else $error("UART clock gate does not follow bit 2");

  spi_gate_a: assert property (gate_write_p(PCG_POS_SPI, 1))
    else $error("SPI clock gate does not follow bit 1");

  audio_gate_a: assert property (gate_write_p(PCG_POS_AUDIO3, 0))
    else $error("Audio port 3 clock gate does not follow bit 0");

  reg_two_read_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_bus.wr && i_bus.addr == 16'h1c03) ##1 (i_bus.rd && i_bus.addr == 16'h1c03)
      |=> o_rdata == $past(i_bus.wdata, 2))
    else $error("Second gating register not reachable at 1C03h");

  reg_one_read_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_bus.rd && i_bus.addr == PCG_OFS_ONE)
      |=> o_rdata == {{(PCG_DW-PCG_ONE_W){1'b0}}, $past(st.gate_one)})
    else $error("First gating register does not read back as written");

  read_one_cycle_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      !$past(i_bus.rd) |-> o_rdata == '0)
    else $error("Read data present outside the cycle after a read");

  uart_violation_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_bus.wr && i_bus.addr == PCG_OFS_ONE && i_bus.wdata[PCG_POS_SERIAL] && lat_en[2]
       && !i_serial_stop_ack)
      ##1 !(i_bus.wr && i_bus.addr == PCG_OFS_STAT && i_bus.wdata[PCG_STAT_VIOL])
      |-> o_stop_violation [*2])
    else $error("UART stop without acknowledge not flagged");

  ////////////////////////////////////////////////////////////////////////////////
  // Status flag checks
  viol_clear_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_bus.wr && i_bus.addr == PCG_OFS_STAT && i_bus.wdata[PCG_STAT_VIOL])
      |=> !o_stop_violation)
    else $error("Status flag not cleared by a one in bit 0");

  viol_sticky_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (o_stop_violation && !(i_bus.wr && i_bus.addr == PCG_OFS_STAT && i_bus.wdata[PCG_STAT_VIOL]))
      |=> o_stop_violation)
    else $error("Status flag dropped without a clear");

  viol_raise_cause_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      $rose(o_stop_violation)
      |-> $past(i_bus.wr && i_bus.addr == PCG_OFS_ONE && i_bus.wdata[PCG_POS_SERIAL] && !i_serial_stop_ack))
    else $error("Status flag raised without an unacknowledged UART stop");

  acked_stop_clean_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_bus.wr && i_bus.addr == PCG_OFS_ONE && i_serial_stop_ack && !o_stop_violation)
      |=> !o_stop_violation)
    else $error("Acknowledged UART stop raised the status flag");

  stat_read_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_bus.rd && i_bus.addr == PCG_OFS_STAT)
      |=> (o_rdata[PCG_STAT_VIOL] == $past(o_stop_violation))
          && (o_rdata[PCG_STAT_ACK] == $past(i_serial_stop_ack)))
    else $error("Status read does not show flag and acknowledge");

  ////////////////////////////////////////////////////////////////////////////////
  // Second gating register checks
  reg_two_write_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_bus.wr && i_bus.addr == PCG_OFS_TWO)
      |=> o_gate_ctrl_two == $past(i_bus.wdata))
    else $error("Second gating register does not take the write");

  reg_two_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      !(i_bus.wr && i_bus.addr == PCG_OFS_TWO)
      |=> $stable(o_gate_ctrl_two))
    else $error("Second gating register changed without a write");

  reg_two_readback_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_bus.rd && i_bus.addr == PCG_OFS_TWO)
      |=> o_rdata == $past(o_gate_ctrl_two))
    else $error("Second gating register read does not match its contents");

  ////////////////////////////////////////////////////////////////////////////////
  // Read port and gate enable checks
  unmapped_read_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_bus.rd && i_bus.addr != PCG_OFS_ONE && i_bus.addr != PCG_OFS_TWO
       && i_bus.addr != PCG_OFS_STAT)
      |=> o_rdata == '0)
    else $error("Unmapped address does not read zero");

  reserved_readback_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_bus.wr && i_bus.addr == PCG_OFS_ONE) ##1 (i_bus.rd && i_bus.addr == PCG_OFS_ONE)
      |=> o_rdata[PCG_POS_RSVD] == $past(i_bus.wdata[PCG_POS_RSVD], 2))
    else $error("Reserved bit does not read back as written");

  gate_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      !(i_bus.wr && i_bus.addr == PCG_OFS_ONE)
      |=> $stable(lat_en))
    else $error("Gate enables changed without a write");

  read_no_write_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      i_bus.rd
      |=> $stable(o_gate_ctrl_two) && $stable(lat_en) && $stable(o_stop_violation))
    else $error("A read changed register state");

  write_rdata_zero_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      i_bus.wr
      |=> o_rdata == '0)
    else $error("Read data present after a write");

  reset_state_a: assert property (
    @(posedge i_ref_clk)
      !i_resetn
      |=> (o_rdata == '0) && (o_gate_ctrl_two == '0) && !o_stop_violation
          && (lat_en == '1))
    else $error("Reset state not all clocks running and registers clear");

  generate
    for (genvar k = 0; k < PCG_NGATES; k++) begin : g_chk
      gate_high_stable_a: assert property (
        @(negedge i_ref_clk) disable iff (!i_resetn)
          (lat_en[k] == lat_at_rise[k]) && (o_periph_clk[k] == lat_en[k]))
        else $error("Gate enable changed while the clock was high");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Cover points
  twowire_stop_c: cover property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      $fell(lat_en[5]));

  uart_stop_acked_c: cover property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      i_serial_stop_ack ##1 $fell(lat_en[2]));

  violation_cleared_c: cover property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      o_stop_violation ##1 !o_stop_violation);

  reg_two_roundtrip_c: cover property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_bus.wr && i_bus.addr == PCG_OFS_TWO) ##1 (i_bus.rd && i_bus.addr == PCG_OFS_TWO));

  uart_stop_unacked_c: cover property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
      !i_serial_stop_ack ##1 $rose(o_stop_violation));

endmodule // pcg_gate_ctrl

//--- src/pcg_pkg.sv
// Package: constants, register map and carrier types of the peripheral clock gate block
package pcg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus and register widths
  localparam int PCG_AW      = 16;
  localparam int PCG_DW      = 16;
  localparam int PCG_ONE_W   = 7;
  localparam int PCG_NGATES  = 6;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [PCG_AW-1:0] PCG_OFS_ONE  = 16'h1c02;
  localparam logic [PCG_AW-1:0] PCG_OFS_TWO  = 16'h1c03;
  localparam logic [PCG_AW-1:0] PCG_OFS_STAT = 16'h1c04;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions of the first gating register
  localparam int PCG_POS_AUDIO3  = 0;
  localparam int PCG_POS_SPI     = 1;
  localparam int PCG_POS_SERIAL  = 2;
  localparam int PCG_POS_DMA0    = 3;
  localparam int PCG_POS_CARD0   = 4;
  localparam int PCG_POS_RSVD    = 5;
  localparam int PCG_POS_TWOWIRE = 6;

  // Status register fields
  localparam int PCG_STAT_VIOL = 0;
  localparam int PCG_STAT_ACK  = 1;

  // Reset values: every clock running
  localparam logic [PCG_ONE_W-1:0] PCG_RST_ONE = 7'h00;
  localparam logic [PCG_DW-1:0]    PCG_RST_TWO = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic [PCG_AW-1:0] addr;
    logic [PCG_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } pcg_bus_req_t;

  typedef struct packed {
    logic [PCG_ONE_W-1:0] gate_one;
    logic [PCG_DW-1:0]    gate_two;
    logic [PCG_DW-1:0]    rdata;
    logic                 stop_viol;
  } pcg_state_t;

  // Gate output index to bit position in the first gating register
  function automatic int pcg_gate_pos(input int idx);
    case (idx)
      0:       return PCG_POS_AUDIO3;
      1:       return PCG_POS_SPI;
      2:       return PCG_POS_SERIAL;
      3:       return PCG_POS_DMA0;
      4:       return PCG_POS_CARD0;
      default: return PCG_POS_TWOWIRE;
    endcase
  endfunction

endpackage
